//--- src/clock_select_and_standby.sv
// Oscillator selection, system and base timer clock division, and standby sequencing, with APB registers.
// Assumes oscillator ticks are one-cycle pulses synchronous to core_clk_i, and the CPU core
// reports standby instructions and interrupt acceptance as pulses on the same clock.
`include "clock_select_defines.svh"
`default_nettype none
module clock_select_and_standby #(
  parameter int SYS_DIV_W = 3,
  parameter int BT_CNT_W  = 8
) (
  // Clock and reset
  input  wire logic                            core_clk_i,
  input  wire logic                            nrst_i,
  // APB slave
  input  wire logic                            psel_i,
  input  wire logic                            penable_i,
  input  wire logic                            pwrite_i,
  input  wire logic [31:0]                     paddr_i,
  input  wire logic [31:0]                     pwdata_i,
  input  wire logic [3:0]                      pstrb_i,
  output logic      [31:0]                     prdata_o,
  output logic                                 pready_o,
  output logic                                 pslverr_o,
  // Oscillator ticks
  input  wire logic                            ceramic_tick_i,
  input  wire logic                            crystal_tick_i,
  input  wire logic                            rc_tick_i,
  // CPU core and interrupt sources
  input  wire logic                            pause_cmd_i,
  input  wire logic                            deep_cmd_i,
  input  wire logic                            xkeep_cmd_i,
  input  wire logic                            wake_req_i,
  input  wire logic                            irq_accept_en_i,
  input  wire logic                            irq_accepted_i,
  // Oscillator controls
  output logic                                 ceramic_osc_en_o,
  output logic                                 crystal_osc_en_o,
  output logic                                 rc_osc_en_o,
  output logic                                 crystal_pins_osc_o,
  // Clock enables and power state
  output logic                                 sys_clk_en_o,
  output logic                                 bt_clk_en_o,
  output logic                                 cpu_run_o,
  output logic                                 periph_run_o,
  output logic                                 periph_crystal_run_o,
  output clock_select_pkg::power_mode_e        mode_o
);
  import clock_select_pkg::*;

  // Registers and state.
  logic [7:0]           osc_ctrl_r;
  logic [7:0]           osc_ctrl_nxt;
  logic [7:0]           clk_div_r;
  logic [7:0]           clk_div_nxt;
  power_mode_e          mode_r;
  power_mode_e          mode_nxt;
  logic [31:0]          prdata_r;
  logic                 pready_r;
  logic                 pslverr_r;
  logic [1:0]           act_sel_r;
  logic [SYS_DIV_W-1:0] act_div_r;
  logic [6:0]           sys_cnt_r;
  logic [BT_CNT_W-1:0]  bt_cnt_r;
  logic                 sys_clk_en_r;
  logic                 bt_clk_en_r;
  logic                 cer_en_r;
  logic                 xtal_en_r;
  logic                 rc_en_r;
  logic                 xpin_r;
  logic                 cpu_run_r;
  logic                 periph_run_r;
  logic                 periph_xtal_run_r;


  // Bus decode.
  // The register indices are not word aligned, so each index is scaled to a byte address.
  // Only the low byte lane carries register data; the upper lanes read as zero.
  // An unmapped address answers with an error and never touches a register.

  wire logic [31:0] osc_ctrl_addr = `OSC_CTRL_INDEX << 2;
  wire logic [31:0] clk_div_addr  = `CLK_DIV_INDEX << 2;
  wire logic        hit_osc   = (paddr_i == osc_ctrl_addr);
  wire logic        hit_div   = (paddr_i == clk_div_addr);
  wire logic        setup     = psel_i & ~penable_i;
  wire logic        wr_commit = psel_i & penable_i & pready_r & pwrite_i & pstrb_i[0] & ~pslverr_r;
  wire logic [7:0]  rd_byte   = hit_osc ? osc_ctrl_r : (hit_div ? clk_div_r : 8'h00);

  // Register fields.
  // The mixed ceramic type codes are forbidden settings; they are treated as oscillation off,
  // which is the safe reading if software writes one by mistake.

  wire logic [1:0] sel_field    = osc_ctrl_r[`OCR_SEL_MSB:`OCR_SEL_LSB];
  wire logic       rc_stop      = osc_ctrl_r[`OCR_RC_STOP_BIT];
  wire logic       cer_type_ok  = osc_ctrl_r[`OCR_CER_HI_BIT] & osc_ctrl_r[`OCR_CER_LO_BIT];
  wire logic       xtal_pin     = osc_ctrl_r[`OCR_XTAL_PIN_BIT];
  wire logic       cer_run      = osc_ctrl_r[`OCR_CER_RUN_BIT];
  wire logic       xtal_run     = osc_ctrl_r[`OCR_XTAL_RUN_BIT];
  wire logic       bt_src_sys   = clk_div_r[`CDR_BT_SRC_BIT];
  wire logic [1:0] bt_div       = clk_div_r[`CDR_BT_DIV_MSB:`CDR_BT_DIV_LSB];
  wire logic [SYS_DIV_W-1:0] sys_div = clk_div_r[`CDR_SYS_DIV_MSB:`CDR_SYS_DIV_LSB];

  // Mode qualifiers.
  // Pause leaves every oscillator and peripheral alone, so only the two standby modes mask.

  wire logic in_deep  = (mode_r == MODE_DEEP);
  wire logic in_xkeep = (mode_r == MODE_XKEEP);
  wire logic standby  = in_deep | in_xkeep;

  // Oscillator run states; crystal-keep only masks the registers, so release restores them.
  wire logic cer_on  = cer_type_ok & cer_run & ~standby;
  wire logic xtal_on = xtal_pin & xtal_run & ~in_deep;
  wire logic rc_on   = ~rc_stop & ~standby;

  // Source tick selection of the active (already switched) source.
  // A tick from a stopped oscillator is ignored, so a stale tick cannot advance the divider.
  // The selection follows the active copy of the select field, not the register itself,
  // because the register may change in the middle of a system clock period.

  wire logic cer_tick  = ceramic_tick_i & cer_en_r;
  wire logic xtal_tick = crystal_tick_i & xtal_en_r;
  wire logic rc_tick   = rc_tick_i & rc_en_r;
  wire logic src_tick  = (act_sel_r == `SEL_CRYSTAL) ? xtal_tick :
                         (act_sel_r == `SEL_CERAMIC) ? cer_tick : rc_tick;
  wire logic act_src_on = (act_sel_r == `SEL_CRYSTAL) ? xtal_en_r :
                          (act_sel_r == `SEL_CERAMIC) ? cer_en_r : rc_en_r;

  // System divider: a pulse when the low act_div bits of the count are all ones.
  // The counter is seven bits wide, enough for the largest ratio of one hundred and twenty-eight.
  // Comparing under a mask lets one counter serve every ratio without a second compare tree.

  wire logic [6:0] div_mask = 7'((8'h01 << act_div_r) - 8'h01);
  wire logic       sys_wrap = src_tick & ((sys_cnt_r & div_mask) == div_mask);
  wire logic       sys_pulse = sys_wrap & ~in_deep;
  // Switching only at a wrap, or while the old source is dead, keeps every period whole.
  wire logic       switch_ok = sys_wrap | ~act_src_on;

  // Base timer divider over system clock pulses.
  // The exponent needs four bits: the largest ratio is two to the eighth.
  // With the crystal as base timer source the pulse is the gated crystal tick itself.

  wire logic [3:0]          bt_log2  = 4'(`BT_DIV_BASE_LOG2) + {2'b00, bt_div};
  wire logic [BT_CNT_W-1:0] bt_mask  = BT_CNT_W'((9'h001 << bt_log2) - 9'h001);
  wire logic                bt_wrap  = sys_pulse & ((bt_cnt_r & bt_mask) == bt_mask);
  wire logic                bt_pulse = bt_src_sys ? bt_wrap : xtal_tick;

  // Standby sequencing.
  // A wake request already pending at a standby command skips the standby mode entirely.
  // Commands are only honoured in normal operation; in pause or standby they are ignored,
  // since the core cannot execute an instruction there.
  // Pause wins over the standby commands when several arrive together.

  wire logic wake_dest_run = irq_accept_en_i;
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      MODE_RUN: begin
        if (pause_cmd_i) begin
          mode_nxt = MODE_PAUSE;
        end else if (deep_cmd_i | xkeep_cmd_i) begin
          if (wake_req_i) begin
            mode_nxt = wake_dest_run ? MODE_RUN : MODE_PAUSE;
          end else begin
            mode_nxt = deep_cmd_i ? MODE_DEEP : MODE_XKEEP;
          end
        end
      end
      MODE_PAUSE: begin
        if (irq_accepted_i) begin
          mode_nxt = MODE_RUN;
        end
      end
      MODE_DEEP: begin
        if (wake_req_i) begin
          mode_nxt = wake_dest_run ? MODE_RUN : MODE_PAUSE;
        end
      end
      MODE_XKEEP: begin
        if (wake_req_i) begin
          mode_nxt = wake_dest_run ? MODE_RUN : MODE_PAUSE;
        end
      end
      default: begin
        mode_nxt = MODE_RUN;
      end
    endcase
  end

  // Deep standby entry clears both registers so that wake comes back on the RC oscillator.
  // The clear wins over a register write landing in the same cycle.

  wire logic deep_entry = (mode_r == MODE_RUN) & deep_cmd_i & ~pause_cmd_i & ~wake_req_i;

  always_comb begin
    osc_ctrl_nxt = osc_ctrl_r;
    clk_div_nxt  = clk_div_r;
    if (deep_entry) begin
      osc_ctrl_nxt = `STANDBY_CLEAR;
      clk_div_nxt  = `STANDBY_CLEAR;
    end else if (wr_commit & hit_osc) begin
      osc_ctrl_nxt = pwdata_i[7:0];
    end else if (wr_commit & hit_div) begin
      clk_div_nxt  = pwdata_i[7:0] & `CDR_WRITE_MASK;
    end
  end

  // Registers and mode.
  // Crystal-keep standby does not touch the registers; the masks above restore the old state.

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      osc_ctrl_r <= `OSC_CTRL_RESET;
      clk_div_r  <= `CLK_DIV_RESET;
      mode_r     <= MODE_RUN;
    end else begin
      osc_ctrl_r <= osc_ctrl_nxt;
      clk_div_r  <= clk_div_nxt;
      mode_r     <= mode_nxt;
    end
  end

  // APB answer: prepared in the setup cycle, so the access phase completes at once.
  // Read data and the error flag hold until the next setup cycle.
  // Writes commit at the access edge, never in the setup cycle.

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup;
      if (setup) begin
        prdata_r  <= {24'h00_0000, rd_byte};
        pslverr_r <= ~(hit_osc | hit_div);
      end
    end
  end

  // Oscillator enables.
  // The enables lag the register and mode by one cycle; the RC oscillator runs out of reset.

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      cer_en_r  <= 1'b0;
      xtal_en_r <= 1'b0;
      rc_en_r   <= 1'b1;
      xpin_r    <= 1'b0;
    end else begin
      cer_en_r  <= cer_on;
      xtal_en_r <= xtal_on;
      rc_en_r   <= rc_on;
      xpin_r    <= xtal_pin;
    end
  end

  // System clock divider and glitch-free switch.
  // A new source or ratio waits for the end of the current period, so no period is cut short.
  // If the old source has stopped, waiting would hang the clock, so the switch is taken at once.

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      act_sel_r <= 2'h0;
      act_div_r <= '0;
      sys_cnt_r <= 7'h00;
    end else begin
      if (switch_ok) begin
        act_sel_r <= sel_field;
        act_div_r <= sys_div;
        sys_cnt_r <= 7'h00;
      end else if (src_tick) begin
        sys_cnt_r <= sys_cnt_r + 7'h01;
      end
    end
  end

  // Base timer divider and clock enable outputs.
  // The count only advances on system pulses, so it freezes in deep standby with the rest.

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      bt_cnt_r     <= '0;
      sys_clk_en_r <= 1'b0;
      bt_clk_en_r  <= 1'b0;
    end else begin
      if (sys_pulse) begin
        bt_cnt_r <= bt_wrap ? '0 : bt_cnt_r + BT_CNT_W'(1);
      end
      sys_clk_en_r <= sys_pulse;
      bt_clk_en_r  <= bt_pulse;
    end
  end

  // Run indications, registered from the next mode so they stay aligned with mode_o.
  // Peripherals on the crystal keep running in every mode but deep standby.
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      cpu_run_r         <= 1'b1;
      periph_run_r      <= 1'b1;
      periph_xtal_run_r <= 1'b1;
    end else begin
      cpu_run_r         <= (mode_nxt == MODE_RUN);
      periph_run_r      <= (mode_nxt == MODE_RUN) | (mode_nxt == MODE_PAUSE);
      periph_xtal_run_r <= (mode_nxt != MODE_DEEP);
    end
  end

  // Outputs.
  // Every output below comes straight from a flip-flop.

  assign prdata_o             = prdata_r;
  assign pready_o             = pready_r;
  assign pslverr_o            = pslverr_r;
  assign ceramic_osc_en_o     = cer_en_r;
  assign crystal_osc_en_o     = xtal_en_r;
  assign rc_osc_en_o          = rc_en_r;
  assign crystal_pins_osc_o   = xpin_r;
  assign sys_clk_en_o         = sys_clk_en_r;
  assign bt_clk_en_o          = bt_clk_en_r;
  assign mode_o               = mode_r;
  assign cpu_run_o            = cpu_run_r;
  assign periph_run_o         = periph_run_r;
  assign periph_crystal_run_o = periph_xtal_run_r;
endmodule : clock_select_and_standby
`default_nettype wire

//--- src/clock_select_defines.svh
// Register indices, field positions and reset values of the clock select and standby block.
// Assumes inclusion by bare name from files that need these constants.
`ifndef CLOCK_SELECT_DEFINES_SVH
`define CLOCK_SELECT_DEFINES_SVH
`define OSC_CTRL_INDEX      32'h0000_7f0a
`define CLK_DIV_INDEX       32'h0000_7f0b
`define OSC_CTRL_RESET      8'h00
`define CLK_DIV_RESET       8'h00
`define STANDBY_CLEAR       8'h00
`define OCR_CER_HI_BIT      7
`define OCR_SEL_MSB         6
`define OCR_SEL_LSB         5
`define OCR_RC_STOP_BIT     4
`define OCR_CER_LO_BIT      3
`define OCR_XTAL_PIN_BIT    2
`define OCR_CER_RUN_BIT     1
`define OCR_XTAL_RUN_BIT    0
`define CDR_BT_SRC_BIT      7
`define CDR_BT_DIV_MSB      5
`define CDR_BT_DIV_LSB      4
`define CDR_SYS_DIV_MSB     2
`define CDR_SYS_DIV_LSB     0
`define CDR_WRITE_MASK      8'hb7
`define SEL_CRYSTAL         2'h3
`define SEL_CERAMIC         2'h2
`define BT_DIV_BASE_LOG2    5
`endif

//--- src/clock_select_pkg.sv
// Types shared by the clock select and standby block.
// Assumes the defines header sits beside it.
`default_nettype none
package clock_select_pkg;
  typedef enum logic [1:0] {
    MODE_RUN   = 2'b00,
    MODE_PAUSE = 2'b01,
    MODE_DEEP  = 2'b10,
    MODE_XKEEP = 2'b11
  } power_mode_e;
endpackage : clock_select_pkg
`default_nettype wire

//--- testbench/clock_select_assertions.sv
// Concurrent checks on the standby sequencing and oscillator enables of the block.
// Assumes it is bound to the block's top module and sees its ports only.
`default_nettype none
module clock_select_assertions
  import clock_select_pkg::*;
(
  // Clock and reset
  input wire logic                        core_clk_i,
  input wire logic                        nrst_i,
  // CPU core and interrupt sources
  input wire logic                        pause_cmd_i,
  input wire logic                        deep_cmd_i,
  input wire logic                        xkeep_cmd_i,
  input wire logic                        wake_req_i,
  input wire logic                        irq_accept_en_i,
  input wire logic                        irq_accepted_i,
  // Block outputs
  input wire logic                        ceramic_osc_en_o,
  input wire logic                        crystal_osc_en_o,
  input wire logic                        rc_osc_en_o,
  input wire logic                        sys_clk_en_o,
  input wire logic                        cpu_run_o,
  input wire logic                        periph_run_o,
  input wire logic                        periph_crystal_run_o,
  input wire clock_select_pkg::power_mode_e mode_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  AST_MODE_DECODE: assert property (cpu_run_o == (mode_o == MODE_RUN) && periph_crystal_run_o == (mode_o != MODE_DEEP)
    && periph_run_o == (mode_o inside {MODE_RUN, MODE_PAUSE})) else $error("run outputs disagree with mode");
  AST_PAUSE_ENTRY: assert property (mode_o == MODE_RUN && pause_cmd_i |=> mode_o == MODE_PAUSE)
    else $error("pause command not taken");
  AST_PAUSE_EXIT: assert property (mode_o == MODE_PAUSE && irq_accepted_i |=> mode_o == MODE_RUN)
    else $error("pause did not end on accepted interrupt");
  AST_PENDING_WAKE: assert property (mode_o == MODE_RUN && (deep_cmd_i || xkeep_cmd_i) && !pause_cmd_i && wake_req_i
    |=> mode_o == ($past(irq_accept_en_i) ? MODE_RUN : MODE_PAUSE)) else $error("pending wake not honoured");
  AST_STANDBY_WAKE: assert property ((mode_o == MODE_DEEP || mode_o == MODE_XKEEP) && wake_req_i
    |=> mode_o == ($past(irq_accept_en_i) ? MODE_RUN : MODE_PAUSE)) else $error("wrong mode after wake");
  AST_DEEP_QUIET: assert property (mode_o == MODE_DEEP && $past(mode_o) == MODE_DEEP && $past(mode_o, 2) == MODE_DEEP
    |-> !(ceramic_osc_en_o || crystal_osc_en_o || rc_osc_en_o || sys_clk_en_o))
    else $error("activity in deep standby");
  AST_XKEEP_QUIET: assert property (mode_o == MODE_XKEEP && $past(mode_o) == MODE_XKEEP && $past(mode_o, 2) == MODE_XKEEP
    |-> !ceramic_osc_en_o && !rc_osc_en_o) else $error("oscillator running in crystal-keep standby");
  AST_RC_AFTER_DEEP: assert property ($fell(mode_o == MODE_DEEP) |=> rc_osc_en_o)
    else $error("RC oscillator off after deep standby");
  AST_RC_AFTER_RESET: assert property ($rose(nrst_i) |-> rc_osc_en_o && mode_o == MODE_RUN)
    else $error("RC oscillator off after reset");
endmodule : clock_select_assertions

bind clock_select_and_standby clock_select_assertions u_chk (.core_clk_i, .nrst_i, .pause_cmd_i, .deep_cmd_i,
  .xkeep_cmd_i, .wake_req_i, .irq_accept_en_i, .irq_accepted_i, .ceramic_osc_en_o, .crystal_osc_en_o, .rc_osc_en_o,
  .sys_clk_en_o, .cpu_run_o, .periph_run_o, .periph_crystal_run_o, .mode_o);
`default_nettype wire

//--- testbench/osc_tick_model.sv
// Oscillator model: free-running period counters whose ticks are gated by the block's enables.
// Assumes the enables are registered on core_clk_i.
`default_nettype none
module osc_tick_model #(
  parameter int CER_P  = 3,
  parameter int XTAL_P = 7,
  parameter int RC_P   = 2
) (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic nrst_i,
  // Enables from the block
  input  wire logic ceramic_osc_en_i,
  input  wire logic crystal_osc_en_i,
  input  wire logic crystal_pins_osc_i,
  input  wire logic rc_osc_en_i,
  // Ticks to the block
  output logic      ceramic_tick_o,
  output logic      crystal_tick_o,
  output logic      rc_tick_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cer_r, xtal_r, rc_r;
  // A stopped oscillator never ticks, and the crystal needs its pins as well.
  assign ceramic_tick_o = ceramic_osc_en_i && cer_r == 8'h00;
  assign crystal_tick_o = crystal_osc_en_i && crystal_pins_osc_i && xtal_r == 8'h00;
  assign rc_tick_o      = rc_osc_en_i && rc_r == 8'h00;
  always_ff @(posedge core_clk_i) begin
    cer_r  <= (!nrst_i || cer_r == 8'(CER_P - 1)) ? 8'h00 : cer_r + 8'h01;
    xtal_r <= (!nrst_i || xtal_r == 8'(XTAL_P - 1)) ? 8'h00 : xtal_r + 8'h01;
    rc_r   <= (!nrst_i || rc_r == 8'(RC_P - 1)) ? 8'h00 : rc_r + 8'h01;
  end
endmodule : osc_tick_model
`default_nettype wire

//--- testbench/tb_clock_select_and_standby.sv
// Self-checking bench: APB register access, clock division by period measurement, standby sequencing.
// Assumes the block, its package and defines header, the oscillator model and the checker are compiled first.
`include "clock_select_defines.svh"
`default_nettype none
module tb_clock_select_and_standby;
  timeunit 1ns;
  timeprecision 1ps;
  import clock_select_pkg::*;
  localparam int CER_P = 3, XTAL_P = 7, RC_P = 2;
  localparam int STAB [4] = '{RC_P, RC_P, CER_P, XTAL_P};
  localparam logic [11:0] OTAB [4] = '{12'h08a_a, 12'h00a_2, 12'h017_5, 12'h004_3};
  localparam logic [31:0] OSC_A = `OSC_CTRL_INDEX * 4, DIV_A = `CLK_DIV_INDEX * 4;
  logic core_clk_i = 1'b0, nrst_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [31:0] paddr_i = 32'h0, pwdata_i = 32'h0, prdata_o, rd;
  logic [3:0] pstrb_i = 4'hf, osc;
  logic pause_cmd_i = 1'b0, deep_cmd_i = 1'b0, xkeep_cmd_i = 1'b0, wake_req_i = 1'b0;
  logic irq_accept_en_i = 1'b0, irq_accepted_i = 1'b0, pready_o, pslverr_o, err;
  logic ceramic_tick_i, crystal_tick_i, rc_tick_i, ceramic_osc_en_o, crystal_osc_en_o, rc_osc_en_o;
  logic crystal_pins_osc_o, sys_clk_en_o, bt_clk_en_o, cpu_run_o, periph_run_o, periph_crystal_run_o;
  logic [2:0] runs;
  power_mode_e mode_o;
  int errors = 0, n_compared = 0, cyc = 0, gapn;
  assign osc = {ceramic_osc_en_o, crystal_osc_en_o, rc_osc_en_o, crystal_pins_osc_o};
  assign runs = {cpu_run_o, periph_run_o, periph_crystal_run_o};

  clock_select_and_standby dut (.core_clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
    .prdata_o, .pready_o, .pslverr_o, .ceramic_tick_i, .crystal_tick_i, .rc_tick_i, .pause_cmd_i, .deep_cmd_i,
    .xkeep_cmd_i, .wake_req_i, .irq_accept_en_i, .irq_accepted_i, .ceramic_osc_en_o, .crystal_osc_en_o, .rc_osc_en_o,
    .crystal_pins_osc_o, .sys_clk_en_o, .bt_clk_en_o, .cpu_run_o, .periph_run_o, .periph_crystal_run_o, .mode_o);
  osc_tick_model #(.CER_P(CER_P), .XTAL_P(XTAL_P), .RC_P(RC_P)) partner (.core_clk_i, .nrst_i,
    .ceramic_osc_en_i(ceramic_osc_en_o), .crystal_osc_en_i(crystal_osc_en_o), .crystal_pins_osc_i(crystal_pins_osc_o),
    .rc_osc_en_i(rc_osc_en_o), .ceramic_tick_o(ceramic_tick_i), .crystal_tick_o(crystal_tick_i), .rc_tick_o(rc_tick_i));

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One idle cycle follows every transfer, so a following call never drives psel twice in one step.
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, wr, a, d};
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n == 20) errors++;
    {rd, err} = {prdata_o, pslverr_o};
    {psel_i, penable_i} <= 2'b00;
    @(posedge core_clk_i);
  endtask : apb

  // Returns the spacing of the third enable pulse, after any switch has settled at a wrap.
  task automatic gap(input logic bt, output int k);
    repeat (3) begin
      k = 0;
      do begin
        @(posedge core_clk_i);
        k++;
      end while ((bt ? bt_clk_en_o : sys_clk_en_o) !== 1'b1 && k < 2000);
    end
  endtask : gap

  task automatic cmd(input int c);
    {pause_cmd_i, deep_cmd_i, xkeep_cmd_i, irq_accepted_i} <= 4'h8 >> c;
    @(posedge core_clk_i);
    {pause_cmd_i, deep_cmd_i, xkeep_cmd_i, irq_accepted_i} <= 4'h0;
    @(posedge core_clk_i);
  endtask : cmd

  task automatic wake;
    wake_req_i <= 1'b1;
    @(posedge core_clk_i);
    wake_req_i <= 1'b0;
    @(posedge core_clk_i);
  endtask : wake

  initial begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      wrap_up();
    end
  end

  initial begin
    repeat (16) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    apb(1'b0, OSC_A, 32'h0);
    chk("osc_reset", rd, 32'h0);
    apb(1'b0, DIV_A, 32'h0);
    chk("div_reset", rd, 32'h0);
    apb(1'b0, 32'h0, 32'h0);
    chk("unmapped_err", 32'(err), 32'h1);
    apb(1'b1, DIV_A, 32'hff);
    apb(1'b0, DIV_A, 32'h0);
    chk("div_fields", rd, 32'hb7);
    foreach (OTAB[i]) begin
      apb(1'b1, OSC_A, 32'(OTAB[i][11:4]));
      repeat (2) @(posedge core_clk_i);
      chk("osc_enables", 32'(osc), 32'(OTAB[i][3:0]));
    end
    apb(1'b1, OSC_A, 32'h05);
    for (int d = 0; d < 8; d++) begin
      apb(1'b1, DIV_A, 32'(d));
      gap(1'b0, gapn);
      chk("sys_div", 32'(gapn), 32'(RC_P << d));
    end
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, DIV_A, 32'h80 | 32'(c << 4));
      gap(1'b1, gapn);
      chk("bt_div", 32'(gapn), 32'(RC_P * (32 << c)));
    end
    apb(1'b1, DIV_A, 32'h0);
    gap(1'b1, gapn);
    chk("bt_crystal", 32'(gapn), 32'(XTAL_P));
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, OSC_A, 32'h8f | 32'(s << 5));
      gap(1'b0, gapn);
      chk("sys_sel", 32'(gapn), 32'(STAB[s]));
    end
    cmd(0);
    chk("pause_runs", {29'h0, runs}, 32'h3);
    cmd(3);
    chk("pause_exit", 32'(mode_o), 32'(MODE_RUN));
    cmd(2);
    @(posedge core_clk_i);
    chk("xkeep_osc", {29'h0, runs, osc == 4'h5}, 32'h3);
    wake();
    chk("xkeep_exit", 32'(mode_o), 32'(MODE_PAUSE));
    @(posedge core_clk_i);
    chk("xkeep_restore", 32'(osc), 32'hf);
    gap(1'b0, gapn);
    chk("xkeep_sel", 32'(gapn), 32'(XTAL_P));
    cmd(3);
    irq_accept_en_i <= 1'b1;
    wake_req_i <= 1'b1;
    cmd(1);
    chk("pending_wake", 32'(mode_o), 32'(MODE_RUN));
    wake_req_i <= 1'b0;
    cmd(1);
    @(posedge core_clk_i);
    chk("deep_quiet", {27'h0, runs, osc}, 32'h0);
    wake();
    chk("deep_exit", 32'(mode_o), 32'(MODE_RUN));
    gap(1'b0, gapn);
    chk("deep_rc", 32'(gapn), 32'(RC_P));
    wrap_up();
  end
endmodule : tb_clock_select_and_standby
`default_nettype wire
